// [hdl/toc_output.sv]
// Threshold output controller for one discrete output, built-in or virtual, APB slave.
// Assumes channel values and alarm flags arrive from logic on CLOCK.
//
// Chosen here: the APB register port and the address map.
`timescale 1ns/100ps
`default_nettype none
`include "toc_params.svh"

module toc_output #(
  parameter int unsigned         TICK_CYCLES = `TOC_TICK_CYCLES,
  parameter toc_pkg::toc_kind_type OUT_KIND  = toc_pkg::TOC_KIND_VIRTUAL
) (
  input  wire logic                      CLOCK,
  input  wire logic                      RST_N,
  input  wire logic                      PSEL,
  input  wire logic                      PENABLE,
  input  wire logic                      PWRITE,
  input  wire logic [`TOC_ADDR_W-1:0]    PADDR,
  input  wire logic [31:0]               PWDATA,
  output logic      [31:0]               PRDATA,
  output logic                           PREADY,
  output logic                           PSLVERR,
  input  wire logic signed [31:0]        SRC_VALUE,
  input  wire logic signed [31:0]        LVLA_VALUE,
  input  wire logic signed [31:0]        LVLB_VALUE,
  input  wire logic                      SRC_ERROR_STATUS,
  input  wire logic                      SOURCE_UNDER_RANGE_STATUS,
  input  wire logic                      SOURCE_OVER_RANGE_STATUS,
  output logic      [`TOC_SEL_W-1:0]     SRC_SEL,
  output logic      [`TOC_SEL_W-1:0]     LVLA_SEL,
  output logic      [`TOC_SEL_W-1:0]     LVLB_SEL,
  output logic                           RELAY_STATE,
  output logic                           ALARM_ACTIVE
);
  import toc_pkg::*;

  // --------------------------------------------------------------------------
  // Functions
  // --------------------------------------------------------------------------
  function automatic logic is_mapped(input logic [`TOC_ADDR_W-1:0] a);
    is_mapped = (a <= `TOC_OFF_INFO) && (a[1:0] == 2'b00);
  endfunction : is_mapped

  // Widened sum keeps level plus hysteresis from wrapping
  function automatic logic signed [33:0] shift_lvl(input logic signed [31:0] l,
                                                   input logic signed [31:0] h,
                                                   input logic up);
    shift_lvl = up ? (34'(l) + 34'(h)) : (34'(l) - 34'(h));
  endfunction : shift_lvl

  function automatic logic sel_ok(input logic [`TOC_SEL_W-1:0] s);
    sel_ok = (s < `TOC_MAX_CHANNELS);
  endfunction : sel_ok

  // --------------------------------------------------------------------------
  // Registers
  // --------------------------------------------------------------------------
  toc_mode_type         mode_r;
  toc_react_type        react_r;
  logic                 lsrc_r;
  logic signed [31:0]   level_r;
  logic signed [31:0]   upper_r;
  logic signed [31:0]   hyst_r;
  logic [31:0]          on_dly_r;
  logic [31:0]          off_dly_r;
  logic [31:0]          min_on_r;
  logic [31:0]          min_off_r;
  logic [31:0]          fill_r;
  logic                 cond_r;
  toc_state_type        state_r;
  logic [31:0]          dur_cnt_r;
  logic [31:0]          dly_cnt_r;
  logic                 tick;

  logic                 acc;
  logic                 wr_en;
  logic                 bad_wr;
  logic [31:0]          rd_word;
  logic                 alarm;

  toc_tick_gen #(
    .TICK_CYCLES (TICK_CYCLES)
  ) u_tick (
    .CLOCK (CLOCK),
    .RST_N (RST_N),
    .TICK  (tick)
  );

  // --------------------------------------------------------------------------
  // APB slave: access phase lasts two cycles, write lands with PREADY
  // --------------------------------------------------------------------------
  assign acc   = PSEL & PENABLE;
  assign wr_en = acc & PREADY & PWRITE & ~PSLVERR;

  always_comb begin
    bad_wr = 1'b0;
    if (PWRITE) begin
      case (PADDR)
        `TOC_OFF_CTRL: begin
          bad_wr = (PWDATA[`TOC_MODE_MSB:`TOC_MODE_LSB] > 3'(TOC_MODE_PWM)) ||
                   (PWDATA[`TOC_REACT_MSB:`TOC_REACT_LSB] > 3'(TOC_REACT_TIMED_ON)) ||
                   ((PWDATA[`TOC_MODE_MSB:`TOC_MODE_LSB] == 3'(TOC_MODE_PWM)) &&
                    (OUT_KIND != TOC_KIND_SSR));
        end
        `TOC_OFF_SEL: begin
          bad_wr = !sel_ok(PWDATA[`TOC_SRC_MSB:`TOC_SRC_LSB]) ||
                   !sel_ok(PWDATA[`TOC_LVLA_MSB:`TOC_LVLA_LSB]) ||
                   !sel_ok(PWDATA[`TOC_LVLB_MSB:`TOC_LVLB_LSB]);
        end
        `TOC_OFF_STATUS, `TOC_OFF_INFO: bad_wr = 1'b1;
        default: bad_wr = 1'b0;
      endcase
    end
  end

  always_comb begin
    rd_word = `TOC_RST_WORD;
    case (PADDR)
      `TOC_OFF_CTRL: begin
        rd_word[`TOC_MODE_MSB:`TOC_MODE_LSB]   = mode_r;
        rd_word[`TOC_REACT_MSB:`TOC_REACT_LSB] = react_r;
        rd_word[`TOC_LSRC_BIT]                 = lsrc_r;
      end
      `TOC_OFF_SEL: begin
        rd_word[`TOC_SRC_MSB:`TOC_SRC_LSB]   = SRC_SEL;
        rd_word[`TOC_LVLA_MSB:`TOC_LVLA_LSB] = LVLA_SEL;
        rd_word[`TOC_LVLB_MSB:`TOC_LVLB_LSB] = LVLB_SEL;
      end
      `TOC_OFF_LEVEL:   rd_word = level_r;
      `TOC_OFF_UPPER:   rd_word = upper_r;
      `TOC_OFF_HYST:    rd_word = hyst_r;
      `TOC_OFF_ON_DLY:  rd_word = on_dly_r;
      `TOC_OFF_OFF_DLY: rd_word = off_dly_r;
      `TOC_OFF_MIN_ON:  rd_word = min_on_r;
      `TOC_OFF_MIN_OFF: rd_word = min_off_r;
      `TOC_OFF_FILL:    rd_word = fill_r;
      `TOC_OFF_STATUS: begin
        rd_word[`TOC_ST_OUT_BIT]   = state_r;
        rd_word[`TOC_ST_ALARM_BIT] = ALARM_ACTIVE;
        rd_word[`TOC_ST_COND_BIT]  = cond_r;
      end
      `TOC_OFF_INFO: begin
        rd_word[`TOC_INFO_TOT_LSB+:8] = `TOC_OUT_TOTAL;
        rd_word[`TOC_INFO_VIR_LSB+:8] = `TOC_OUT_VIRTUAL;
        rd_word[`TOC_INFO_SSR_BIT]    = (OUT_KIND == TOC_KIND_SSR);
      end
      default: rd_word = `TOC_RST_WORD;
    endcase
  end

  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      PREADY  <= 1'b0;
      PRDATA  <= `TOC_RST_WORD;
      PSLVERR <= 1'b0;
    end else begin
      PREADY  <= acc & ~PREADY;
      PSLVERR <= acc & ~PREADY & (!is_mapped(PADDR) | bad_wr);
      if (acc & ~PREADY & ~PWRITE) begin
        PRDATA <= rd_word;
      end
    end
  end

  // Refused writes leave every setting untouched
  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      mode_r    <= TOC_MODE_DISABLED;
      react_r   <= TOC_REACT_HOLD;
      lsrc_r    <= 1'b0;
      SRC_SEL   <= '0;
      LVLA_SEL  <= '0;
      LVLB_SEL  <= '0;
      level_r   <= `TOC_RST_WORD;
      upper_r   <= `TOC_RST_WORD;
      hyst_r    <= `TOC_RST_WORD;
      on_dly_r  <= `TOC_RST_WORD;
      off_dly_r <= `TOC_RST_WORD;
      min_on_r  <= `TOC_RST_WORD;
      min_off_r <= `TOC_RST_WORD;
      fill_r    <= `TOC_RST_WORD;
    end else if (wr_en) begin
      case (PADDR)
        `TOC_OFF_CTRL: begin
          mode_r  <= toc_mode_type'(PWDATA[`TOC_MODE_MSB:`TOC_MODE_LSB]);
          react_r <= toc_react_type'(PWDATA[`TOC_REACT_MSB:`TOC_REACT_LSB]);
          lsrc_r  <= PWDATA[`TOC_LSRC_BIT];
        end
        `TOC_OFF_SEL: begin
          SRC_SEL  <= PWDATA[`TOC_SRC_MSB:`TOC_SRC_LSB];
          LVLA_SEL <= PWDATA[`TOC_LVLA_MSB:`TOC_LVLA_LSB];
          LVLB_SEL <= PWDATA[`TOC_LVLB_MSB:`TOC_LVLB_LSB];
        end
        `TOC_OFF_LEVEL:   level_r   <= PWDATA;
        `TOC_OFF_UPPER:   upper_r   <= PWDATA;
        `TOC_OFF_HYST:    hyst_r    <= PWDATA;
        `TOC_OFF_ON_DLY:  on_dly_r  <= PWDATA;
        `TOC_OFF_OFF_DLY: off_dly_r <= PWDATA;
        `TOC_OFF_MIN_ON:  min_on_r  <= PWDATA;
        `TOC_OFF_MIN_OFF: min_off_r <= PWDATA;
        `TOC_OFF_FILL:    fill_r    <= PWDATA;
        default: ;
      endcase
    end
  end

  // --------------------------------------------------------------------------
  // Comparison with hysteresis
  // --------------------------------------------------------------------------
  logic signed [31:0] lvl_lo;
  logic signed [31:0] lvl_hi;
  logic signed [33:0] v;
  logic               lo_on;
  logic               lo_off;
  logic               hi_on;
  logic               hi_off;
  logic               cond_nxt;

  assign lvl_lo = lsrc_r ? LVLA_VALUE : level_r;
  assign lvl_hi = lsrc_r ? LVLB_VALUE : upper_r;
  assign v      = 34'(SRC_VALUE);
  // Band edges: strictly past the far edge switches, inside the band holds
  assign lo_on  = v > shift_lvl(lvl_lo, hyst_r, 1'b1);
  assign lo_off = v < shift_lvl(lvl_lo, hyst_r, 1'b0);
  assign hi_on  = v > shift_lvl(lvl_hi, hyst_r, 1'b1);
  assign hi_off = v < shift_lvl(lvl_hi, hyst_r, 1'b0);

  always_comb begin
    cond_nxt = cond_r;
    case (mode_r)
      TOC_MODE_ABOVE, TOC_MODE_PWM: begin
        if (lo_on) cond_nxt = 1'b1;
        else if (lo_off) cond_nxt = 1'b0;
      end
      TOC_MODE_BELOW: begin
        if (lo_off) cond_nxt = 1'b1;
        else if (lo_on) cond_nxt = 1'b0;
      end
      TOC_MODE_INSIDE: begin
        if (lo_on && hi_off) cond_nxt = 1'b1;
        else if (lo_off || hi_on) cond_nxt = 1'b0;
      end
      TOC_MODE_OUTSIDE: begin
        if (lo_off || hi_on) cond_nxt = 1'b1;
        else if (lo_on && hi_off) cond_nxt = 1'b0;
      end
      default: cond_nxt = 1'b0;
    endcase
  end

  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      cond_r <= 1'b0;
    end else if (mode_r == TOC_MODE_DISABLED) begin
      cond_r <= 1'b0;
    end else if (tick) begin
      cond_r <= cond_nxt;
    end
  end

  // --------------------------------------------------------------------------
  // Alarm reaction and output state
  // --------------------------------------------------------------------------
  logic       force_en;
  logic       force_val;
  logic       want;
  logic       want_hi;
  logic [31:0] need_dly;
  logic [31:0] need_min;
  logic       may_flip;

  assign alarm = SRC_ERROR_STATUS | SOURCE_UNDER_RANGE_STATUS |
                 SOURCE_OVER_RANGE_STATUS;

  always_comb begin
    force_en  = 1'b0;
    force_val = 1'b0;
    want      = cond_r;
    if (mode_r == TOC_MODE_DISABLED) begin
      force_en = 1'b1;
    end else if (alarm && mode_r == TOC_MODE_PWM) begin
      force_en  = 1'b1;
      force_val = (fill_r != `TOC_RST_WORD);
    end else if (alarm) begin
      case (react_r)
        TOC_REACT_HOLD:      want = state_r;
        TOC_REACT_IMM_OFF:   force_en = 1'b1;
        TOC_REACT_IMM_ON: begin
          force_en  = 1'b1;
          force_val = 1'b1;
        end
        TOC_REACT_TIMED_OFF: want = 1'b0;
        TOC_REACT_TIMED_ON:  want = 1'b1;
        default:             want = state_r;
      endcase
    end
  end

  // Going high uses on-delay and min off; going low the opposite pair
  assign want_hi  = (want == 1'b1);
  assign need_dly = want_hi ? on_dly_r : off_dly_r;
  assign need_min = want_hi ? min_off_r : min_on_r;
  assign may_flip = tick && (want != state_r) && (dly_cnt_r >= need_dly) &&
                    (dur_cnt_r >= need_min);

  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      state_r <= TOC_ST_LOW;
    end else if (force_en) begin
      state_r <= toc_state_type'(force_val);
    end else if (may_flip) begin
      state_r <= toc_state_type'(want);
    end
  end

  // Time in current state, saturating so long holds never wrap
  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      dur_cnt_r <= `TOC_RST_WORD;
    end else if ((force_en && state_r != toc_state_type'(force_val)) ||
                 (!force_en && may_flip)) begin
      dur_cnt_r <= `TOC_RST_WORD;
    end else if (tick && dur_cnt_r != `TOC_CNT_SAT) begin
      dur_cnt_r <= dur_cnt_r + 32'h1;
    end
  end

  // Mismatch time; restarts whenever the wish agrees with the output
  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      dly_cnt_r <= `TOC_RST_WORD;
    end else if (force_en || want == state_r || may_flip) begin
      dly_cnt_r <= `TOC_RST_WORD;
    end else if (tick && dly_cnt_r != `TOC_CNT_SAT) begin
      dly_cnt_r <= dly_cnt_r + 32'h1;
    end
  end

  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      RELAY_STATE  <= 1'b0;
      ALARM_ACTIVE <= 1'b0;
    end else begin
      RELAY_STATE  <= state_r;
      ALARM_ACTIVE <= alarm;
    end
  end

  // --------------------------------------------------------------------------
  // Assertions
  // --------------------------------------------------------------------------
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (!RST_N);

  disabled_low_a: assert property (
    mode_r == TOC_MODE_DISABLED |=> ##1 !RELAY_STATE)
    else $error("output not low while disabled");

  imm_off_a: assert property (
    alarm && mode_r != TOC_MODE_PWM && react_r == TOC_REACT_IMM_OFF |=> state_r == TOC_ST_LOW)
    else $error("immediate off not applied");

  imm_on_a: assert property (
    alarm && mode_r inside {[TOC_MODE_ABOVE:TOC_MODE_OUTSIDE]} &&
    react_r == TOC_REACT_IMM_ON |=> ##1 RELAY_STATE)
    else $error("immediate on not applied");

  hold_a: assert property (
    alarm && mode_r inside {[TOC_MODE_ABOVE:TOC_MODE_OUTSIDE]} &&
    react_r == TOC_REACT_HOLD |=> $stable(state_r))
    else $error("output changed under hold reaction");

  min_on_a: assert property (
    $fell(state_r) && !$past(force_en) |-> $past(dur_cnt_r) >= $past(min_on_r))
    else $error("high state shorter than minimum on time");

  min_off_a: assert property (
    $rose(state_r) && !$past(force_en) |-> $past(dur_cnt_r) >= $past(min_off_r))
    else $error("low state shorter than minimum off time");

  on_delay_a: assert property (
    $rose(state_r) && !$past(force_en) |-> $past(dly_cnt_r) >= $past(on_dly_r) && $past(tick))
    else $error("rise before on delay");

  off_delay_a: assert property (
    $fell(state_r) && !$past(force_en) |-> $past(dly_cnt_r) >= $past(off_dly_r) && $past(tick))
    else $error("fall before off delay");

  apb_ready_a: assert property (
    acc && !PREADY |=> PREADY ##1 !PREADY)
    else $error("ready not one cycle after access start");

  sel_range_a: assert property (
    SRC_SEL < `TOC_MAX_CHANNELS && LVLA_SEL < `TOC_MAX_CHANNELS &&
    LVLB_SEL < `TOC_MAX_CHANNELS)
    else $error("channel select out of range");

  pwm_kind_a: assert property (
    OUT_KIND != TOC_KIND_SSR |-> mode_r != TOC_MODE_PWM)
    else $error("pulse-width mode on non solid-state output");

  rise_c:   cover property ($rose(RELAY_STATE));
  alarm_c:  cover property (alarm && react_r == TOC_REACT_TIMED_ON ##[1:50] $rose(state_r));
  refuse_c: cover property (PREADY && PSLVERR);

endmodule : toc_output

`default_nettype wire

// [hdl/toc_params.svh]
// Constants of the threshold output controller: offsets, fields, resets, timing.
// Assumes inclusion by bare name from the package and the design modules.
`ifndef TOC_PARAMS_SVH
`define TOC_PARAMS_SVH

// ----------------------------------------------------------------------------
// Register offsets (byte addresses, one aligned word each)
// ----------------------------------------------------------------------------
`define TOC_ADDR_W        8
`define TOC_OFF_CTRL      8'h00
`define TOC_OFF_SEL       8'h04
`define TOC_OFF_LEVEL     8'h08
`define TOC_OFF_UPPER     8'h0c
`define TOC_OFF_HYST      8'h10
`define TOC_OFF_ON_DLY    8'h14
`define TOC_OFF_OFF_DLY   8'h18
`define TOC_OFF_MIN_ON    8'h1c
`define TOC_OFF_MIN_OFF   8'h20
`define TOC_OFF_FILL      8'h24
`define TOC_OFF_STATUS    8'h28
`define TOC_OFF_INFO      8'h2c

// ----------------------------------------------------------------------------
// Field layouts
// ----------------------------------------------------------------------------
`define TOC_MODE_MSB      2
`define TOC_MODE_LSB      0
`define TOC_REACT_MSB     6
`define TOC_REACT_LSB     4
`define TOC_LSRC_BIT      8
`define TOC_SEL_W         6
`define TOC_SRC_MSB       5
`define TOC_SRC_LSB       0
`define TOC_LVLA_MSB      13
`define TOC_LVLA_LSB      8
`define TOC_LVLB_MSB      21
`define TOC_LVLB_LSB      16
`define TOC_ST_OUT_BIT    0
`define TOC_ST_ALARM_BIT  1
`define TOC_ST_COND_BIT   2
`define TOC_INFO_TOT_LSB  0
`define TOC_INFO_VIR_LSB  8
`define TOC_INFO_SSR_BIT  16

// ----------------------------------------------------------------------------
// Values, resets and timing
// ----------------------------------------------------------------------------
`define TOC_MAX_CHANNELS  6'd60
`define TOC_OUT_TOTAL     8'd17
`define TOC_OUT_VIRTUAL   8'd16
`define TOC_RST_WORD      32'h0000_0000
`define TOC_CNT_SAT       32'hffff_ffff
`define TOC_CLK_PERIOD_NS 8
`define TOC_TICK_NS       1000000
`define TOC_TICK_CYCLES   (`TOC_TICK_NS / `TOC_CLK_PERIOD_NS)

`endif

// [hdl/toc_pkg.sv]
// Types of the threshold output controller.
// Assumes toc_params.svh on the include path.
`include "toc_params.svh"

package toc_pkg;

  // --------------------------------------------------------------------------
  // Enumerations
  // --------------------------------------------------------------------------
  typedef enum logic [2:0] {
    TOC_MODE_DISABLED = 3'h0,
    TOC_MODE_ABOVE    = 3'h1,
    TOC_MODE_BELOW    = 3'h2,
    TOC_MODE_INSIDE   = 3'h3,
    TOC_MODE_OUTSIDE  = 3'h4,
    TOC_MODE_PWM      = 3'h5
  } toc_mode_type;

  typedef enum logic [2:0] {
    TOC_REACT_HOLD      = 3'h0,
    TOC_REACT_IMM_OFF   = 3'h1,
    TOC_REACT_IMM_ON    = 3'h2,
    TOC_REACT_TIMED_OFF = 3'h3,
    TOC_REACT_TIMED_ON  = 3'h4
  } toc_react_type;

  typedef enum logic [1:0] {
    TOC_KIND_SOUND   = 2'h0,
    TOC_KIND_VIRTUAL = 2'h1,
    TOC_KIND_RELAY   = 2'h2,
    TOC_KIND_SSR     = 2'h3
  } toc_kind_type;

  typedef enum logic {
    TOC_ST_LOW  = 1'b0,
    TOC_ST_HIGH = 1'b1
  } toc_state_type;

endpackage : toc_pkg

// [hdl/toc_tick_gen.sv]
// Periodic time-base tick for the output timers.
// Assumes one clock; tick is a one-cycle pulse every TICK_CYCLES cycles.
`timescale 1ns/100ps
`default_nettype none
`include "toc_params.svh"

module toc_tick_gen #(
  parameter int unsigned TICK_CYCLES = `TOC_TICK_CYCLES
) (
  input  wire logic CLOCK,
  input  wire logic RST_N,
  output logic      TICK
);

  logic [31:0] cnt_r;

  generate
    if (TICK_CYCLES < 2) begin : g_bad
      $error("toc_tick_gen: TICK_CYCLES must be at least 2");
    end
  endgenerate

  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      cnt_r <= 32'h0;
      TICK  <= 1'b0;
    end else if (cnt_r == 32'(TICK_CYCLES - 1)) begin
      cnt_r <= 32'h0;
      TICK  <= 1'b1;
    end else begin
      cnt_r <= cnt_r + 32'h1;
      TICK  <= 1'b0;
    end
  end

endmodule : toc_tick_gen

`default_nettype wire

// [verification/toc_chan_model.sv]
// Partner model: a table of logical channel values feeding the controller.
// Assumes the bench writes tbl just after a rising clock edge.
`timescale 1ns/100ps
`default_nettype none

module toc_chan_model (
  input  wire logic              clk,
  input  wire logic        [5:0] src_sel,
  input  wire logic        [5:0] lvla_sel,
  input  wire logic        [5:0] lvlb_sel,
  output logic signed     [31:0] src_value,
  output logic signed     [31:0] lvla_value,
  output logic signed     [31:0] lvlb_value
);
  // ----------------------------------------
  // Channel table
  // ----------------------------------------
  logic signed [31:0] tbl [60];
  logic        [31:0] noise_r = 32'h0;

  initial foreach (tbl[i]) tbl[i] = 32'sh0;

  // No channel behind the index: moving pattern, never a stale value
  always_ff @(posedge clk) begin
    noise_r <= noise_r + 32'h0101_0101;
  end

  assign src_value  = (src_sel < 6'd60) ? tbl[src_sel] : noise_r;
  assign lvla_value = (lvla_sel < 6'd60) ? tbl[lvla_sel] : noise_r;
  assign lvlb_value = (lvlb_sel < 6'd60) ? tbl[lvlb_sel] : noise_r;
endmodule : toc_chan_model

`default_nettype wire

// [verification/toc_tb_top.sv]
// Self-checking bench for the threshold output controller.
// Assumes a 4-cycle tick and the channel table model as partner.
`timescale 1ns/100ps
`default_nettype none

module threshold_output_controller_tb_top;
  // ----------------------------------------
  // Signals and instances
  // ----------------------------------------
  localparam int      T = 4;
  logic               clk, rst_n, psel, pen, pwr, prdy, perr, rs, aa;
  logic [7:0]         pa;
  logic [31:0]        pwd, prd;
  logic [2:0]         fl;
  logic signed [31:0] sv, la, lb;
  logic [5:0]         ss, las, lbs;
  logic [15:0]        r;
  int                 n_fail, n_compared, l, u, v, md, n;
  time                tf;
  int                 hv [4] = '{105, 111, 95, 89};
  logic [3:0]         he = 4'b0110;

  toc_output #(.TICK_CYCLES(T)) uut (.CLOCK(clk), .RST_N(rst_n), .PSEL(psel),
    .PENABLE(pen), .PWRITE(pwr), .PADDR(pa), .PWDATA(pwd), .PRDATA(prd),
    .PREADY(prdy), .PSLVERR(perr), .SRC_VALUE(sv), .LVLA_VALUE(la),
    .LVLB_VALUE(lb), .SRC_ERROR_STATUS(fl[0]), .SOURCE_UNDER_RANGE_STATUS(fl[1]),
    .SOURCE_OVER_RANGE_STATUS(fl[2]), .SRC_SEL(ss), .LVLA_SEL(las),
    .LVLB_SEL(lbs), .RELAY_STATE(rs), .ALARM_ACTIVE(aa));
  toc_chan_model m (.clk(clk), .src_sel(ss), .lvla_sel(las), .lvlb_sel(lbs),
    .src_value(sv), .lvla_value(la), .lvlb_value(lb));

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  // ----------------------------------------
  // Tasks and reference model
  // ----------------------------------------
  task automatic cyc(input int k);
    repeat (k) @(posedge clk);
  endtask : cyc

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_fail++;
      $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  // Waits for the slave with no fixed latency; the watchdog ends a hang
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     input logic xe, input logic [31:0] xr, input logic cr);
    @(posedge clk);
    psel <= 1'b1; pwr <= w; pa <= a; pwd <= d;
    @(posedge clk);
    pen <= 1'b1;
    @(posedge clk);
    while (prdy !== 1'b1) @(posedge clk);
    chk(perr, xe);
    if (cr) chk(prd, xr);
    psel <= 1'b0; pen <= 1'b0;
  endtask : apb

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d, 1'b0, 32'h0, 1'b0);
  endtask : wr

  // Source steps stay many ticks apart, the scaled once-a-second limit
  task automatic setv(input int x);
    @(posedge clk);
    m.tbl[0] <= x;
  endtask : setv

  function automatic logic [15:0] lfsr(input logic [15:0] x);
    return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
  endfunction : lfsr

  function automatic int want(int mo, int vv, int ll, int uu);
    case (mo)
      1: return vv > ll;
      2: return vv < ll;
      3: return vv > ll && vv < uu;
      4: return vv < ll || vv > uu;
      default: return 0;
    endcase
  endfunction : want

  task automatic summarize();
    if (n_fail == 0 && n_compared > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : summarize

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  initial begin
    {psel, pen, pwr, pa, pwd, fl} = '0;
    n_fail = 0; n_compared = 0; r = 16'h22dc;
    rst_n = 1'b0;
    cyc(10);
    rst_n <= 1'b1;
    apb(1'b0, 8'h2c, 0, 1'b0, 32'h0000_1011, 1'b1);
    apb(1'b0, 8'h28, 0, 1'b0, 32'h0, 1'b1);
    apb(1'b0, 8'h30, 0, 1'b1, 32'h0, 1'b0);
    wr(8'h04, 32'h0002_0100);
    // Odd trials take live limits; stored ones are swapped to tell them apart
    for (int t = 0; t < 10; t++) begin
      r = lfsr(r); l = {r[7:1], 1'b0}; u = l + {r[15:9], 1'b0} + 2;
      r = lfsr(r); v = {r[8:1], 1'b1}; md = t % 5;
      @(posedge clk); m.tbl[0] <= v; m.tbl[1] <= l; m.tbl[2] <= u;
      wr(8'h08, (t % 2) ? u : l);
      wr(8'h0c, (t % 2) ? l : u);
      wr(8'h00, md + (t % 2) * 256);
      cyc(10 * T);
      chk(rs, want(md, v, l, u));
    end
    wr(8'h00, 1); wr(8'h08, 100); wr(8'h10, 10); setv(50); cyc(10 * T);
    for (int i = 0; i < 4; i++) begin
      setv(hv[i]); cyc(10 * T);
      chk(rs, he[i]);
    end
    wr(8'h10, 0);
    for (int k = 0; k < 5; k++) begin
      wr(8'h00, 1 + k * 16); setv((k == 2 || k == 4) ? 50 : 150); cyc(10 * T);
      @(posedge clk); fl[k % 3] <= 1'b1; if (k == 0) m.tbl[0] <= 50;
      cyc(4);
      if (k == 1 || k == 2) chk(rs, k == 2);
      cyc(10 * T);
      chk(aa, 1);
      chk(rs, k % 2 == 0);
      @(posedge clk); fl <= '0; cyc(10 * T);
      chk(rs, k % 2 == 1);
    end
    wr(8'h14, 5); wr(8'h1c, 6); setv(150); n = 0;
    while (rs !== 1'b1 && n < 200) begin @(posedge clk); n++; end
    chk(n >= 5 * T && n <= 9 * T, 1);
    setv(50); n = 0;
    while (rs !== 1'b0 && n < 200) begin @(posedge clk); n++; end
    chk(n >= 4 * T && n <= 9 * T, 1);
    // Minimum off time counts from the fall; off delay counts mismatched ticks
    tf = $time;
    wr(8'h18, 3); wr(8'h20, 7); wr(8'h14, 0); wr(8'h1c, 0); setv(150); n = 0;
    while (rs !== 1'b1 && n < 200) begin @(posedge clk); n++; end
    chk(($time - tf) >= 7 * T * 8 && ($time - tf) <= 9 * T * 8, 1);
    setv(50); n = 0;
    while (rs !== 1'b0 && n < 200) begin @(posedge clk); n++; end
    chk(n >= 4 * T && n <= 6 * T, 1);
    apb(1'b1, 8'h00, 32'h5, 1'b1, 32'h0, 1'b0);
    apb(1'b1, 8'h04, 32'h3c, 1'b1, 32'h0, 1'b0);
    apb(1'b1, 8'h28, 32'h1, 1'b1, 32'h0, 1'b0);
    apb(1'b0, 8'h04, 0, 1'b0, 32'h0002_0100, 1'b1);
    apb(1'b0, 8'h00, 0, 1'b0, 32'h41, 1'b1);
    summarize();
  end

  // Whole run is under two thousand cycles; this cuts a hang short
  initial begin
    cyc(20000);
    n_fail++;
    summarize();
  end
endmodule : threshold_output_controller_tb_top

`default_nettype wire
